//--- hdl/nri_top.sv
// reset handling, link pin and network status indicators
// --------------------------------------------------------------------
// Notes on behaviour
// - low reset forces reset state immediately, ignoring any activity in progress.
// - no send or receive after reset until software sets the go bit.
// - reset initialises command, interrupt mask, data and transmit configuration.
// - internal reset completes ten clock cycles after reset is released.
// - reversed flag idles low; rises after seven inverted pulses or three packets.
// - transmit activity output stretched to 50 ms on every transmit, any port.
// - collision output stretched to 50 ms on every collision, any port.
// - link pin role sampled as reset is released.
// - floating or lamp-loaded link pin at release selects indicator output role.
// - output role drives link pin low while link is intact.
// - output role releases link pin once link is found broken.
// - attachment port selected leaves link pin undriven, pulled high.
// - link pin held low at release makes it input; link checking disabled.
// --------------------------------------------------------------------
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nri_top
    import nri_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        pclk,                  // bus clock, 10 MHz
    input  wire logic        presetn,               // async reset, low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb enable
    input  wire logic        pwrite,                // apb direction
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire logic        tx_event,              // transmit started pulse
    input  wire logic        col_event,             // collision seen pulse
    input  wire logic        lp_seen,               // link pulse received
    input  wire logic        lp_inverted,           // that pulse was inverted
    input  wire logic        pkt_seen,              // packet received
    input  wire logic        pkt_inverted,          // that packet was inverted
    input  wire logic        link_broken,           // link test failed
    input  wire logic        port_select_input,     // pin: high attachment port
    input  wire logic        link_pin_in,           // link pin level
    output logic             link_pin_out,          // link pin drive level
    output logic             link_pin_oe,           // link pin drive enable
    output logic             reversed_wire_flag,    // polarity reversed
    output logic             transmit_activity_out, // stretched transmit
    output logic             collision_out,         // stretched collision
    output logic             tx_enable,             // controller may send
    output logic             rx_enable,             // controller may accept
    output logic             link_check_en,         // link integrity checking on
    output logic      [7:0]  dcr_out,               // data configuration
    output logic      [7:0]  tcr_out,               // transmit configuration
    output logic             irq                    // interrupt, high
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sel_sync_reg;
    logic [1:0] lnk_sync_reg;
    logic [1:0] sel_sync_next;
    logic [1:0] lnk_sync_next;

    always_comb begin
        sel_sync_next = {sel_sync_reg[0], port_select_input};
        lnk_sync_next = {lnk_sync_reg[0], link_pin_in};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_sync_reg <= 2'h0;
            lnk_sync_reg <= 2'h3;   // pull-up level
        end else begin
            sel_sync_reg <= sel_sync_next;
            lnk_sync_reg <= lnk_sync_next;
        end
    end

    logic aui_sel;
    logic pin_level;
    assign aui_sel   = sel_sync_reg[1];
    assign pin_level = lnk_sync_reg[1];

    // ----------------------------------------------------------------
    // reset sequence and link pin role
    // ----------------------------------------------------------------
    logic [3:0] init_cnt_reg;
    logic       role_out_reg;
    logic       init_done_reg;
    logic [3:0] init_cnt_next;
    logic       role_out_next;
    logic       init_done_next;

    always_comb begin
        init_cnt_next  = init_cnt_reg;
        role_out_next  = role_out_reg;
        init_done_next = init_done_reg;
        if (!init_done_reg) begin
            init_cnt_next = init_cnt_reg + 4'h1;
            if (init_cnt_reg == ROLE_SAMPLE_CYC) begin
                role_out_next = pin_level;
            end
            if (init_cnt_next == INIT_CYCLES) begin
                init_done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_reg  <= 4'h0;
            role_out_reg  <= 1'b1;
            init_done_reg <= 1'b0;
        end else begin
            init_cnt_reg  <= init_cnt_next;
            role_out_reg  <= role_out_next;
            init_done_reg <= init_done_next;
        end
    end

    // ----------------------------------------------------------------
    // polarity detection
    // ----------------------------------------------------------------
    logic [2:0] lp_cnt_reg;
    logic [1:0] pkt_cnt_reg;
    logic       rev_reg;
    logic [2:0] lp_cnt_next;
    logic [1:0] pkt_cnt_next;
    logic       rev_next;

    always_comb begin
        lp_cnt_next  = lp_cnt_reg;
        pkt_cnt_next = pkt_cnt_reg;
        rev_next     = rev_reg;
        if (lp_seen) begin
            if (!lp_inverted) begin
                lp_cnt_next  = 3'h0;
                pkt_cnt_next = 2'h0;
                rev_next     = 1'b0;
            end else if (lp_cnt_reg != LP_REV_COUNT) begin
                lp_cnt_next = lp_cnt_reg + 3'h1;
            end
        end
        if (pkt_seen) begin
            if (!pkt_inverted) begin
                pkt_cnt_next = 2'h0;
                lp_cnt_next  = 3'h0;
                rev_next     = 1'b0;
            end else if (pkt_cnt_reg != PKT_REV_COUNT) begin
                pkt_cnt_next = pkt_cnt_reg + 2'h1;
            end
        end
        if (lp_cnt_next == LP_REV_COUNT || pkt_cnt_next == PKT_REV_COUNT) begin
            rev_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_cnt_reg  <= 3'h0;
            pkt_cnt_reg <= 2'h0;
            rev_reg     <= 1'b0;
        end else begin
            lp_cnt_reg  <= lp_cnt_next;
            pkt_cnt_reg <= pkt_cnt_next;
            rev_reg     <= rev_next;
        end
    end

    assign reversed_wire_flag = rev_reg;

    // ----------------------------------------------------------------
    // millisecond tick and indicator stretchers
    // ----------------------------------------------------------------
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic        tick;

    always_comb begin
        tick     = (div_reg == 16'(TICK_CYC - 1));
        div_next = tick ? 16'h0000 : div_reg + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end

    nri_stretch_if tx_if ();
    nri_stretch_if col_if ();

    assign tx_if.trig  = tx_event;
    assign tx_if.tick  = tick;
    assign col_if.trig = col_event;
    assign col_if.tick = tick;

    nri_stretch #(.TICKS(STRETCH_MS)) u_tx_stretch (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (tx_if.stretcher)
    );

    nri_stretch #(.TICKS(STRETCH_MS)) u_col_stretch (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (col_if.stretcher)
    );

    assign transmit_activity_out = tx_if.active;
    assign collision_out         = col_if.active;

    // ----------------------------------------------------------------
    // link pin
    // ----------------------------------------------------------------
    logic link_ok;
    assign link_check_en = ~role_out_reg ? 1'b0 : 1'b1;
    assign link_ok       = ~link_broken | ~link_check_en;
    assign link_pin_out  = 1'b0;
    assign link_pin_oe   = role_out_reg & ~aui_sel & link_ok
                         & (init_cnt_reg > ROLE_SAMPLE_CYC);        // released until role known

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]       cmd_reg;
    logic [7:0]       imr_reg;
    logic [7:0]       dcr_reg;
    logic [7:0]       tcr_reg;
    logic [ISR_W-1:0] isr_reg;
    logic             link_ok_d_reg;
    logic [7:0]       cmd_next;
    logic [7:0]       imr_next;
    logic [7:0]       dcr_next;
    logic [7:0]       tcr_next;
    logic [ISR_W-1:0] isr_next;
    logic [ISR_W-1:0] ev_set;
    logic             wr;
    logic             running;

    assign wr      = psel & penable & pwrite;
    assign running = cmd_reg[CMD_GO_BIT] & ~cmd_reg[CMD_STOP_BIT] & init_done_reg;

    always_comb begin
        cmd_next = cmd_reg;
        imr_next = imr_reg;
        dcr_next = dcr_reg;
        tcr_next = tcr_reg;
        ev_set   = '0;
        ev_set[EV_POL]       = rev_next & ~rev_reg;
        ev_set[EV_LINK_LOST] = link_ok_d_reg & ~link_ok;
        ev_set[EV_COL]       = col_event;
        ev_set[EV_TX]        = tx_event;
        ev_set[EV_INIT_DONE] = init_done_next & ~init_done_reg;
        isr_next = isr_reg;
        if (wr) begin
            case (paddr)
                OFS_CMD: begin
                    if (pwdata[CMD_STOP_BIT]) begin
                        cmd_next[CMD_STOP_BIT] = 1'b1;
                        cmd_next[CMD_GO_BIT]   = 1'b0;
                    end else if (pwdata[CMD_GO_BIT]) begin
                        cmd_next[CMD_GO_BIT]   = 1'b1;
                        cmd_next[CMD_STOP_BIT] = 1'b0;
                    end
                end
                OFS_IMR: imr_next = pwdata[7:0];
                OFS_DCR: dcr_next = pwdata[7:0];
                OFS_TCR: tcr_next = pwdata[7:0];
                OFS_ISR: isr_next = isr_reg & ~pwdata[ISR_W-1:0];
                default: ;
            endcase
        end
        isr_next = isr_next | ev_set;            // set wins over clear
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg       <= CMD_RST;
            imr_reg       <= IMR_RST;
            dcr_reg       <= DCR_RST;
            tcr_reg       <= TCR_RST;
            isr_reg       <= ISR_RST;
            link_ok_d_reg <= 1'b1;
        end else begin
            cmd_reg       <= cmd_next;
            imr_reg       <= imr_next;
            dcr_reg       <= dcr_next;
            tcr_reg       <= tcr_next;
            isr_reg       <= isr_next;
            link_ok_d_reg <= link_ok;
        end
    end

    assign tx_enable = running;
    assign rx_enable = running;
    assign dcr_out   = dcr_reg;
    assign tcr_out   = tcr_reg;
    assign irq       = |(isr_reg & imr_reg[ISR_W-1:0]);

    // ----------------------------------------------------------------
    // apb read side
    // ----------------------------------------------------------------
    logic [7:0] stat;
    logic       mapped;

    always_comb begin
        stat = 8'h00;
        stat[ST_REVERSED]  = rev_reg;
        stat[ST_TX_ACT]    = tx_if.active;
        stat[ST_COL_ACT]   = col_if.active;
        stat[ST_LINK_OK]   = link_ok;
        stat[ST_ROLE_OUT]  = role_out_reg;
        stat[ST_AUI_SEL]   = aui_sel;
        stat[ST_RUNNING]   = running;
        stat[ST_INIT_DONE] = init_done_reg;
        prdata = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            OFS_CMD:  prdata[7:0]       = cmd_reg;
            OFS_IMR:  prdata[7:0]       = imr_reg;
            OFS_DCR:  prdata[7:0]       = dcr_reg;
            OFS_TCR:  prdata[7:0]       = tcr_reg;
            OFS_STAT: prdata[7:0]       = stat;
            OFS_ISR:  prdata[ISR_W-1:0] = isr_reg;
            default:  mapped            = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
endmodule : nri_top
`default_nettype wire

//--- hdl/nri_pkg.sv
// constants shared by the reset and link indicator block
package nri_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD  = 8'h00;
    localparam logic [7:0] OFS_IMR  = 8'h04;
    localparam logic [7:0] OFS_DCR  = 8'h08;
    localparam logic [7:0] OFS_TCR  = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_ISR  = 8'h14;

    // ----------------------------------------------------------------
    // field positions and widths
    // ----------------------------------------------------------------
    localparam int CMD_STOP_BIT = 0;
    localparam int CMD_GO_BIT   = 1;

    localparam int ISR_W        = 5;
    localparam int EV_POL       = 0;
    localparam int EV_LINK_LOST = 1;
    localparam int EV_COL       = 2;
    localparam int EV_TX        = 3;
    localparam int EV_INIT_DONE = 4;

    localparam int ST_REVERSED  = 0;
    localparam int ST_TX_ACT    = 1;
    localparam int ST_COL_ACT   = 2;
    localparam int ST_LINK_OK   = 3;
    localparam int ST_ROLE_OUT  = 4;
    localparam int ST_AUI_SEL   = 5;
    localparam int ST_RUNNING   = 6;
    localparam int ST_INIT_DONE = 7;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0]       CMD_RST = 8'h01;
    localparam logic [7:0]       IMR_RST = 8'h00;
    localparam logic [7:0]       DCR_RST = 8'h00;
    localparam logic [7:0]       TCR_RST = 8'h00;
    localparam logic [ISR_W-1:0] ISR_RST = 5'h00;

    // ----------------------------------------------------------------
    // counts and times
    // ----------------------------------------------------------------
    localparam logic [3:0] INIT_CYCLES     = 4'ha;
    localparam logic [3:0] ROLE_SAMPLE_CYC = 4'h2;
    localparam logic [2:0] LP_REV_COUNT    = 3'h7;
    localparam logic [1:0] PKT_REV_COUNT   = 2'h3;

    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STRETCH_MS     = 50;

endpackage : nri_pkg

//--- hdl/nri_stretch_if.sv
// trigger, time base and result of one pulse stretcher
`timescale 1ns/1ps
`default_nettype none
interface nri_stretch_if;
    logic trig;
    logic tick;
    logic active;
    modport owner     (output trig, output tick, input active);
    modport stretcher (input trig, input tick, output active);
endinterface : nri_stretch_if
`default_nettype wire

//--- hdl/nri_stretch.sv
// retriggerable stretcher counting millisecond ticks
`timescale 1ns/1ps
`default_nettype none
module nri_stretch
    import nri_pkg::*;
#(
    parameter int TICKS = STRETCH_MS
) (
    input  wire logic         pclk,     // bus clock
    input  wire logic         presetn,  // async reset, low
    nri_stretch_if.stretcher  s         // trigger in, active out
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (s.trig) begin
            cnt_next = 8'(TICKS);
        end else if (s.tick && cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign s.active = (cnt_reg != 8'h00);
endmodule : nri_stretch
`default_nettype wire

//--- dv/nri_board.sv
// board model: link pin strap, lamp and internal pull-up
`timescale 1ns/1ps
`default_nettype none
module nri_board (
    input  wire logic link_pin_out, // device drive level
    input  wire logic link_pin_oe,  // device drive enable
    input  wire logic strap_low,    // board ties the pin low
    output logic      link_pin_in   // resolved pin level
);
    // --------------------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------------------
    // open pin or lamp only floats up, a strap pulls it down
    assign link_pin_in = link_pin_oe ? link_pin_out : !strap_low;
endmodule : nri_board
`default_nettype wire

//--- dv/nri_top_checker.sv
// concurrent checks on the ports of the reset and link indicator block
`timescale 1ns/1ps
`default_nettype none
module nri_top_checker
    import nri_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic pclk,                  // bus clock
    input wire logic presetn,               // async reset, low
    input wire logic tx_event,              // transmit pulse
    input wire logic col_event,             // collision pulse
    input wire logic lp_seen,               // link pulse
    input wire logic lp_inverted,           // pulse inverted
    input wire logic pkt_seen,              // packet
    input wire logic pkt_inverted,          // packet inverted
    input wire logic link_broken,           // link failed
    input wire logic port_select_input,     // attachment port
    input wire logic link_pin_oe,           // pin drive enable
    input wire logic reversed_wire_flag,    // polarity flag
    input wire logic transmit_activity_out, // stretched transmit
    input wire logic collision_out,         // stretched collision
    input wire logic tx_enable,             // may send
    input wire logic rx_enable,             // may accept
    input wire logic link_check_en          // link checking on
);
    // --------------------------------------------------------------------
    // properties
    // --------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_tx_start: assert property (tx_event |=> transmit_activity_out)
        else $error("transmit activity missing after transmit");
    chk_tx_hold: assert property ($rose(transmit_activity_out) |-> transmit_activity_out [*8])
        else $error("transmit activity dropped early");
    chk_col_start: assert property (col_event |=> collision_out [*3])
        else $error("collision output missing after collision");
    chk_flag_cause: assert property ($rose(reversed_wire_flag) |-> $past(lp_seen && lp_inverted) || $past(pkt_seen && pkt_inverted))
        else $error("reversed flag rose without inverted input");
    chk_flag_clear: assert property ((lp_seen && !lp_inverted) || (pkt_seen && !pkt_inverted) |=> !reversed_wire_flag)
        else $error("reversed flag kept after correct polarity");
    chk_run_gate: assert property ($rose(presetn) |-> (!tx_enable && !rx_enable) [*8])
        else $error("traffic enabled right after reset");
    chk_broken_off: assert property (link_broken |-> !link_pin_oe)
        else $error("link pin driven with broken link");
    chk_aui_off: assert property (port_select_input [*4] |-> !link_pin_oe)
        else $error("link pin driven with attachment port");
    chk_lamp_on: assert property ((link_check_en && !link_broken && !port_select_input) [*4] |-> link_pin_oe)
        else $error("link pin not driven with good link");
    chk_input_quiet: assert property (!link_check_en |-> !link_pin_oe)
        else $error("link pin driven in input role");
endmodule : nri_top_checker
`default_nettype wire

bind nri_top nri_top_checker #(.TICK_CYC(TICK_CYC)) i_chk (
    .pclk(pclk), .presetn(presetn), .tx_event(tx_event), .col_event(col_event),
    .lp_seen(lp_seen), .lp_inverted(lp_inverted), .pkt_seen(pkt_seen),
    .pkt_inverted(pkt_inverted), .link_broken(link_broken),
    .port_select_input(port_select_input), .link_pin_oe(link_pin_oe),
    .reversed_wire_flag(reversed_wire_flag), .transmit_activity_out(transmit_activity_out),
    .collision_out(collision_out), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .link_check_en(link_check_en)
);

//--- dv/tb_nri_top.sv
// self-checking bench for the reset and link indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_nri_top
    import nri_pkg::*;
;
    localparam int         TK    = 10;
    localparam logic [4:0] E_INV = 5'h01;
    localparam logic [4:0] E_LP  = 5'h02;
    localparam logic [4:0] E_PKT = 5'h04;
    localparam logic [4:0] E_TX  = 5'h08;
    localparam logic [4:0] E_COL = 5'h10;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, dcr_out, tcr_out;
    logic [31:0] pwdata, prdata, rdat;
    logic        tx_event, col_event, lp_seen, lp_inverted, pkt_seen, pkt_inverted;
    logic        link_broken, port_select_input, link_pin_in, link_pin_out, link_pin_oe;
    logic        strap_low, reversed_wire_flag, transmit_activity_out, collision_out;
    logic        tx_enable, rx_enable, link_check_en, irq;
    logic [7:0]  rst_v [4] = '{CMD_RST, IMR_RST, DCR_RST, TCR_RST};
    int          n_mismatch = 0;
    int          tests_run  = 0;

    always #50 pclk = ~pclk;

    nri_top #(.TICK_CYC(TK)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_event(tx_event), .col_event(col_event), .lp_seen(lp_seen),
        .lp_inverted(lp_inverted), .pkt_seen(pkt_seen), .pkt_inverted(pkt_inverted),
        .link_broken(link_broken), .port_select_input(port_select_input),
        .link_pin_in(link_pin_in), .link_pin_out(link_pin_out), .link_pin_oe(link_pin_oe),
        .reversed_wire_flag(reversed_wire_flag), .transmit_activity_out(transmit_activity_out),
        .collision_out(collision_out), .tx_enable(tx_enable), .rx_enable(rx_enable),
        .link_check_en(link_check_en), .dcr_out(dcr_out), .tcr_out(tcr_out), .irq(irq)
    );
    nri_board i_board (
        .link_pin_out(link_pin_out), .link_pin_oe(link_pin_oe),
        .strap_low(strap_low), .link_pin_in(link_pin_in)
    );

    // --------------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            n_mismatch++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic ee);
        xfer(a, 1'b0, 32'h0);
        chk($sformatf("read %h", a), rdat & m, e);
        chk($sformatf("slverr %h", a), rerr, ee);
    endtask : rd

    // events are one-cycle pulses, taken at the edge that lowers them
    task automatic drive(input logic [4:0] v, input int n);
        repeat (n) begin
            @(posedge pclk);
            {col_event, tx_event, pkt_seen, lp_seen, lp_inverted} <= v;
            pkt_inverted <= v[0];
            @(posedge pclk);
            {col_event, tx_event, pkt_seen, lp_seen} <= 4'h0;
        end
        #1;
    endtask : drive

    task automatic rst_regs();
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), 32'hff, {24'h0, rst_v[i]}, 1'b0);
        end
    endtask : rst_regs

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_event, col_event, lp_seen, lp_inverted, pkt_seen, pkt_inverted} = '0;
        {link_broken, port_select_input, strap_low} = '0;
        cyc(4);
        presetn <= 1'b1;
        cyc(9);
        rd(OFS_STAT, 32'h90, 32'h90, 1'b0);
        rst_regs();
        rd(8'h18, 32'hffffffff, 32'h0, 1'b1);
        wr_dcr: begin
            xfer(OFS_DCR, 1'b1, 32'h5a);
            xfer(OFS_TCR, 1'b1, 32'ha5);
        end
        cyc(0);
        chk("dcr_out", dcr_out, 32'h5a);
        chk("tcr_out", tcr_out, 32'ha5);
        chk("tx_enable idle", tx_enable, 32'h0);
        chk("irq masked", irq, 32'h0);
        rd(OFS_ISR, 32'h10, 32'h10, 1'b0);
        xfer(OFS_IMR, 1'b1, 32'h10);
        cyc(1);
        chk("irq raised", irq, 32'h1);
        xfer(OFS_ISR, 1'b1, 32'h10);
        cyc(1);
        chk("irq cleared", irq, 32'h0);
        xfer(OFS_CMD, 1'b1, 32'h2);
        cyc(1);
        chk("tx_enable go", tx_enable, 32'h1);
        chk("rx_enable go", rx_enable, 32'h1);
        for (int k = 0; k < 2; k++) begin
            port_select_input <= k[0];
            drive(k ? E_COL : E_TX, 1);
            chk("stretch on", k ? collision_out : transmit_activity_out, 32'h1);
            cyc(49 * TK - 15);
            chk("stretch held", k ? collision_out : transmit_activity_out, 32'h1);
            cyc(30);
            chk("stretch off", k ? collision_out : transmit_activity_out, 32'h0);
        end
        port_select_input <= 1'b0;
        drive(E_LP | E_INV, 6);
        chk("flag six pulses", reversed_wire_flag, 32'h0);
        drive(E_LP | E_INV, 1);
        chk("flag seven pulses", reversed_wire_flag, 32'h1);
        drive(E_LP, 1);
        chk("flag cleared", reversed_wire_flag, 32'h0);
        drive(E_PKT | E_INV, 2);
        drive(E_PKT, 1);
        drive(E_PKT | E_INV, 2);
        chk("flag counts cleared", reversed_wire_flag, 32'h0);
        drive(E_PKT | E_INV, 1);
        chk("flag three packets", reversed_wire_flag, 32'h1);
        drive(E_LP | E_INV, 6);
        drive(E_PKT, 1);
        drive(E_LP | E_INV, 1);
        chk("flag cross cleared", reversed_wire_flag, 32'h0);
        cyc(4);
        chk("lamp lit", link_pin_in, 32'h0);
        link_broken <= 1'b1;
        cyc(1);
        chk("lamp off", link_pin_in, 32'h1);
        link_broken       <= 1'b0;
        port_select_input <= 1'b1;
        cyc(4);
        chk("pin pulled up", link_pin_in, 32'h1);
        port_select_input <= 1'b0;
        drive(E_TX, 1);
        cyc(3);
        @(posedge pclk);
        presetn   <= 1'b0;
        strap_low <= 1'b1;
        #1;
        chk("activity at reset", transmit_activity_out, 32'h0);
        chk("tx_enable at reset", tx_enable, 32'h0);
        cyc(4);
        presetn <= 1'b1;
        cyc(12);
        chk("input role", link_check_en, 32'h0);
        rd(OFS_STAT, 32'h10, 32'h0, 1'b0);
        strap_low <= 1'b0;
        cyc(4);
        chk("role latched", link_check_en, 32'h0);
        rst_regs();
        results();
    end
endmodule : tb_nri_top
`default_nettype wire
